// >>> hdl/nvm_seq_pkg.sv
// Constants, types and field layout for the nonvolatile memory sequencer.
// How it works
// - Flash erases or programs one 32-word row.
// - Keys 0x55 then 0xAA precede start.
// - Flash cycle stalls the CPU throughout.
// - Hardware clears start bit at cycle end.
// - Start bit launches flash and EEPROM cycles.
// - Software may set, never clear, start.
// - Enable bit gates writes, zero at power-up.
// - Interrupting reset sets error, keeps low address.
// - EEPROM handles single words and 16-word blocks.
// - EEPROM sits at 0x7FF000 to 0x7FFFFE.
// - EEPROM location from upper plus lower address.
// - EEPROM word write takes about 2 ms.
// - EEPROM cycles never stall the CPU.
// - EEPROM read during cycle gives unspecified data.
// - Completion sets done flag until software clears.
// - Table low read returns word at address.
// - Lower address captures last table address bits.
// - Flash erase or program lasts about 2 ms.
// - Start needs enable set by earlier write.
`default_nettype none
package nvm_seq_pkg;

    localparam int CLK_MHZ    = 100;
    localparam int OP_TIME_US = 2000;
    localparam int OP_CYCLES  = OP_TIME_US * CLK_MHZ;

    localparam logic [15:0] IDX_CONTROL = 16'h0760;
    localparam logic [15:0] IDX_ADR_LOW = 16'h0762;
    localparam logic [15:0] IDX_ADR_UP  = 16'h0764;
    localparam logic [15:0] IDX_KEY     = 16'h0766;
    localparam logic [15:0] IDX_STATUS  = 16'h0768;

    localparam logic [15:0] ADDR_CONTROL = {IDX_CONTROL[13:0], 2'b00};
    localparam logic [15:0] ADDR_ADR_LOW = {IDX_ADR_LOW[13:0], 2'b00};
    localparam logic [15:0] ADDR_ADR_UP  = {IDX_ADR_UP[13:0], 2'b00};
    localparam logic [15:0] ADDR_KEY     = {IDX_KEY[13:0], 2'b00};
    localparam logic [15:0] ADDR_STATUS  = {IDX_STATUS[13:0], 2'b00};

    localparam int START_BIT  = 15;
    localparam int ENABLE_BIT = 14;
    localparam int ERROR_BIT  = 13;
    localparam int DONE_BIT   = 0;
    localparam int OP_ERASE   = 6;
    localparam int OP_EE      = 2;
    localparam int OP_MULTI   = 0;

    localparam logic [6:0]  OP_RESET  = 7'h00;
    localparam logic [7:0]  KEY_FIRST  = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'haa;

    localparam int ROW_WORDS   = 32;
    localparam int BLOCK_WORDS = 16;
    localparam logic [23:0] EE_FIRST = 24'h7ff000;
    localparam logic [23:0] EE_LAST  = 24'h7ffffe;
    localparam int EE_WORDS = 2048;
    localparam logic [15:0] ERASED_WORD    = 16'hffff;
    localparam logic [15:0] BUSY_READ_WORD = 16'h0bad;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } key_e;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_RUN    = 2'b01,
        SEQ_COMMIT = 2'b10
    } seq_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        high;
        logic [23:0] addr;
        logic [15:0] wdata;
    } tbl_req_s;

endpackage

`default_nettype wire

// >>> hdl/nvm_program_erase_sequencer.sv
// Erase and program sequencer for flash rows and data EEPROM.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module nvm_program_erase_sequencer #(
    parameter int FLASH_CYCLES = nvm_seq_pkg::OP_CYCLES,
    parameter int EE_CYCLES    = nvm_seq_pkg::OP_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  master_clear_reset,
    input  wire logic                  watchdog_timeout,
    input  wire nvm_seq_pkg::tbl_req_s tbl,
    output var  logic [15:0]           tbl_rdata,
    output var  logic                  cpu_stall,
    output var  logic                  memory_done_flag,
    output var  logic                  flash_commit,
    output var  logic                  flash_erase,
    output var  logic [23:0]           flash_row
);
    import nvm_seq_pkg::*;

    // Control register fields and address registers.
    logic        ctl_start;
    logic        ctl_enable;
    logic        ctl_error;
    logic [6:0]  op_sel;
    logic [15:0] adr_low;
    logic [7:0]  adr_up;

    // Operation captured at start so later control writes cannot disturb it.
    logic [6:0]  run_op;
    logic [17:0] timer;
    key_e        key_st;
    seq_e        seq_st;

    // Row write latches and the EEPROM array.
    logic [23:0] wlatch [0:ROW_WORDS-1];
    logic [15:0] ee_mem [0:EE_WORDS-1];

    // True when a program address falls inside the EEPROM window.
    function automatic logic in_ee(input logic [23:0] a);
        in_ee = (a >= EE_FIRST) && (a <= EE_LAST);
    endfunction

    // Word index of a program address within the EEPROM array.
    function automatic logic [10:0] ee_index(input logic [23:0] a);
        ee_index = a[11:1];
    endfunction

    // Latch slot picked by a program address.
    function automatic logic [4:0] slot(input logic [23:0] a);
        slot = a[5:1];
    endfunction

    // Bus decode for the access phase in which a transfer completes.
    logic access;
    logic wr_ctl;
    logic wr_low;
    logic wr_up;
    logic wr_key;
    logic wr_stat;
    logic abort;
    logic busy;
    logic start_ok;
    logic [23:0] cur_addr;
    logic run_ee;

    assign access   = psel && penable && pready;
    assign wr_ctl   = access && pwrite && (paddr == ADDR_CONTROL);
    assign wr_low   = access && pwrite && (paddr == ADDR_ADR_LOW);
    assign wr_up    = access && pwrite && (paddr == ADDR_ADR_UP);
    assign wr_key   = access && pwrite && (paddr == ADDR_KEY);
    assign wr_stat  = access && pwrite && (paddr == ADDR_STATUS);
    assign abort    = master_clear_reset || watchdog_timeout;
    assign busy     = (seq_st != SEQ_IDLE);
    assign cur_addr = {adr_up, adr_low};
    assign run_ee   = busy && run_op[OP_EE];

    // Start needs the key, an enable set beforehand and an idle sequencer.
    assign start_ok = wr_ctl && pwdata[START_BIT] && !ctl_start
                      && ctl_enable
                      && (key_st == KEY_OPEN)
                      && !busy && !abort;

    // Zero-wait slave: answer is prepared in setup, shown in access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == ADDR_CONTROL) begin
                    prdata[START_BIT]  <= ctl_start;
                    prdata[ENABLE_BIT] <= ctl_enable;
                    prdata[ERROR_BIT]  <= ctl_error;
                    prdata[6:0]        <= op_sel;
                end else if (paddr == ADDR_ADR_LOW) begin
                    prdata[15:0] <= adr_low;
                end else if (paddr == ADDR_ADR_UP) begin
                    prdata[7:0] <= adr_up;
                end else if (paddr == ADDR_KEY) begin
                    prdata <= 32'h0000_0000; // Key register is write-only.
                end else if (paddr == ADDR_STATUS) begin
                    prdata[DONE_BIT] <= memory_done_flag;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Unlock tracker: 0x55 then 0xAA back to back opens one start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_st <= KEY_IDLE;
        end else if (abort || wr_ctl) begin
            key_st <= KEY_IDLE; // A control write uses up the unlock.
        end else if (wr_key) begin
            if (pwdata[7:0] == KEY_FIRST) begin
                key_st <= KEY_HALF;
            end else if (pwdata[7:0] == KEY_SECOND && key_st == KEY_HALF) begin
                key_st <= KEY_OPEN;
            end else begin
                key_st <= KEY_IDLE;
            end
        end else if (access && pwrite && key_st == KEY_HALF) begin
            key_st <= KEY_IDLE;
        end
    end

    // Enable and operation fields; enable is cleared by a system reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_enable <= 1'b0;
            op_sel     <= OP_RESET;
        end else if (abort) begin
            ctl_enable <= 1'b0;
            op_sel     <= OP_RESET;
        end else if (wr_ctl) begin
            ctl_enable <= pwdata[ENABLE_BIT];
            op_sel     <= pwdata[6:0];
        end
    end

    // Start bit: software only sets it, hardware clears it at the end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_start <= 1'b0;
        end else if (start_ok) begin
            ctl_start <= 1'b1;
        end else if (abort || seq_st == SEQ_COMMIT) begin
            ctl_start <= 1'b0;
        end
    end

    // Error flag: set by an interrupted cycle; set beats a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_error <= 1'b0;
        end else if (abort && busy) begin
            ctl_error <= 1'b1;
        end else if (wr_ctl && !pwdata[ERROR_BIT]) begin
            ctl_error <= 1'b0;
        end
    end

    // Done flag: set on completion, cleared by writing one to it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_done_flag <= 1'b0;
        end else if (seq_st == SEQ_COMMIT) begin
            memory_done_flag <= 1'b1;
        end else if (wr_stat && pwdata[DONE_BIT]) begin
            memory_done_flag <= 1'b0;
        end
    end

    // Address registers follow table accesses or direct writes, frozen while busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adr_low <= 16'h0000;
            adr_up  <= 8'h00;
        end else if (!busy) begin
            if ((tbl.wr || tbl.rd) && !abort) begin
                adr_low <= tbl.addr[15:0];
                adr_up  <= tbl.addr[23:16];
            end else if (wr_low) begin
                adr_low <= pwdata[15:0];
            end else if (wr_up) begin
                adr_up <= pwdata[7:0];
            end
        end
    end

    // Sequencer: timed cycle, aborted at once by a system reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_st <= SEQ_IDLE;
            timer  <= 18'h00000;
            run_op <= OP_RESET;
        end else if (abort) begin
            seq_st <= SEQ_IDLE;
            timer  <= 18'h00000;
        end else begin
            case (seq_st)
                SEQ_IDLE: begin
                    if (start_ok) begin
                        seq_st <= SEQ_RUN;
                        run_op <= op_sel;
                        if (op_sel[OP_EE]) begin
                            timer <= 18'(EE_CYCLES - 1);
                        end else begin
                            timer <= 18'(FLASH_CYCLES - 1);
                        end
                    end
                end
                SEQ_RUN: begin
                    if (timer == 18'h00000) begin
                        seq_st <= SEQ_COMMIT;
                    end else begin
                        timer <= timer - 18'h00001;
                    end
                end
                SEQ_COMMIT: begin
                    seq_st <= SEQ_IDLE;
                end
                default: begin
                    seq_st <= SEQ_IDLE;
                end
            endcase
        end
    end

    // CPU stall covers a flash cycle from start to completion only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_stall <= 1'b0;
        end else if (abort) begin
            cpu_stall <= 1'b0;
        end else if (start_ok) begin
            cpu_stall <= !op_sel[OP_EE];
        end else if (seq_st == SEQ_COMMIT) begin
            cpu_stall <= 1'b0;
        end
    end

    // Flash row commit strobe to the array; row base aligned to 32 words.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_commit <= 1'b0;
            flash_erase  <= 1'b0;
            flash_row    <= 24'h000000;
        end else begin
            flash_commit <= (seq_st == SEQ_COMMIT) && !run_op[OP_EE] && !abort;
            if (seq_st == SEQ_COMMIT) begin
                flash_erase <= run_op[OP_ERASE];
                flash_row   <= {cur_addr[23:6], 6'h00};
            end
        end
    end

    // Table writes fill one latch half; ignored while a cycle runs.
    always_ff @(posedge pclk) begin
        if (tbl.wr && !busy) begin
            if (tbl.high) begin
                wlatch[slot(tbl.addr)][23:16] <= tbl.wdata[7:0];
            end else begin
                wlatch[slot(tbl.addr)][15:0] <= tbl.wdata;
            end
        end
    end

    // EEPROM commit: single word or 16-word block, erase or program.
    always_ff @(posedge pclk) begin
        if (seq_st == SEQ_COMMIT && run_op[OP_EE] && !abort && in_ee(cur_addr)) begin
            if (run_op[OP_MULTI]) begin
                for (int k = 0; k < BLOCK_WORDS; k++) begin
                    if (run_op[OP_ERASE]) begin
                        ee_mem[{cur_addr[11:5], 4'(k)}] <= ERASED_WORD;
                    end else begin
                        ee_mem[{cur_addr[11:5], 4'(k)}] <=
                            wlatch[{cur_addr[5], 4'(k)}][15:0];
                    end
                end
            end else if (run_op[OP_ERASE]) begin
                ee_mem[ee_index(cur_addr)] <= ERASED_WORD;
            end else begin
                ee_mem[ee_index(cur_addr)] <= wlatch[slot(cur_addr)][15:0];
            end
        end
    end

    // Table reads: EEPROM word, or latch contents for flash addresses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_rdata <= 16'h0000;
        end else if (tbl.rd) begin
            if (in_ee(tbl.addr) && !tbl.high) begin
                if (run_ee) begin
                    tbl_rdata <= BUSY_READ_WORD;
                end else begin
                    tbl_rdata <= ee_mem[ee_index(tbl.addr)];
                end
            end else if (tbl.high) begin
                tbl_rdata <= {8'h00, wlatch[slot(tbl.addr)][23:16]};
            end else begin
                tbl_rdata <= wlatch[slot(tbl.addr)][15:0];
            end
        end
    end

    // Checks on the sequencer behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence first_key_s;
        wr_key && pwdata[7:0] == KEY_FIRST && !abort;
    endsequence

    sequence second_key_s;
        wr_key && pwdata[7:0] == KEY_SECOND && !abort;
    endsequence

    unlock_pair_a: assert property (
        first_key_s ##1 !abort ##1 !abort ##[0:1] second_key_s |=> key_st == KEY_OPEN)
        else $error("Key pair did not unlock.");

    locked_start_a: assert property (
        wr_ctl && key_st != KEY_OPEN && !ctl_start |=> !ctl_start)
        else $error("Start accepted without unlock.");

    enable_first_a: assert property (
        wr_ctl && !ctl_enable && !ctl_start |=> !ctl_start && !busy)
        else $error("Start and enable set together.");

    start_hold_a: assert property (
        ctl_start && seq_st == SEQ_RUN && !abort && timer != 18'h00000
        |=> ctl_start)
        else $error("Start bit dropped during a cycle.");

    self_clear_a: assert property (
        seq_st == SEQ_COMMIT && !abort |=> !ctl_start && memory_done_flag)
        else $error("Completion did not clear start or set done.");

    flash_stall_a: assert property (
        start_ok && !op_sel[OP_EE] |=> cpu_stall throughout (seq_st == SEQ_RUN)[*2])
        else $error("Flash cycle did not stall the CPU.");

    ee_no_stall_a: assert property (
        run_ee |-> !cpu_stall)
        else $error("EEPROM cycle stalled the CPU.");

    abort_error_a: assert property (
        busy && abort |=> ctl_error && !busy && $stable(adr_low))
        else $error("Interrupted cycle not flagged.");

    done_sticky_a: assert property (
        memory_done_flag && !(wr_stat && pwdata[DONE_BIT]) |=> memory_done_flag)
        else $error("Done flag lost without a clear.");

    busy_read_a: assert property (
        tbl.rd && run_ee && in_ee(tbl.addr) && !tbl.high
        |=> tbl_rdata == BUSY_READ_WORD)
        else $error("EEPROM read during cycle not marked.");

endmodule

`default_nettype wire

// >>> verif/cpu_table_model.sv
// Core-side model that issues table writes and table reads to the sequencer.
`timescale 1ns/10ps
`default_nettype none

module cpu_table_model (
    input  wire logic                  pclk,
    output var  nvm_seq_pkg::tbl_req_s tbl,
    input  wire logic [15:0]           tbl_rdata
);
    import nvm_seq_pkg::*;

    // No table instruction is issued until a task asks for one.
    initial begin
        tbl = '0;
    end

    // One table write per call; afterwards the fields show the inverse, not the old value.
    task automatic twrite(input logic [23:0] a, input logic [15:0] d, input logic hi);
        @(posedge pclk);
        tbl <= '{1'b1, 1'b0, hi, a, d};
        @(posedge pclk);
        tbl <= '{1'b0, 1'b0, ~hi, ~a, ~d};
    endtask

    // One low-word table read; the data is taken once the registered answer has landed.
    task automatic tread(input logic [23:0] a, output logic [15:0] d);
        @(posedge pclk);
        tbl <= '{1'b0, 1'b1, 1'b0, a, 16'h0000};
        @(posedge pclk);
        tbl <= '{1'b0, 1'b0, 1'b1, ~a, 16'hffff};
        #1;
        d = tbl_rdata;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb_nvm_program_erase_sequencer.sv
// Self-checking bench for the program and erase sequencer.
`timescale 1ns/10ps
`default_nettype none

module tb_nvm_program_erase_sequencer;
    import nvm_seq_pkg::*;
    localparam int RUN = 20;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        mcr, wdt, cpu_stall, done, commit, erase;
    logic [15:0] paddr, tbl_rdata, td;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] row;
    tbl_req_s    tbl;
    row_s        rows [9];
    int          error_cnt = 0;
    int          tests_run = 0;

    // Sequencer with short cycle counts, and the core model feeding its table port.
    nvm_program_erase_sequencer #(.FLASH_CYCLES(RUN), .EE_CYCLES(RUN)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_clear_reset(mcr), .watchdog_timeout(wdt), .tbl(tbl), .tbl_rdata(tbl_rdata),
        .cpu_stall(cpu_stall), .memory_done_flag(done), .flash_commit(commit),
        .flash_erase(erase), .flash_row(row));
    cpu_table_model core (.pclk(pclk), .tbl(tbl), .tbl_rdata(tbl_rdata));

    // 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Loads the control value, opens the key and sets the start bit.
    task automatic start_op(input logic [31:0] ctl);
        apb(1'b1, ADDR_CONTROL, ctl);
        apb(1'b1, ADDR_KEY, 32'h0000_0055);
        apb(1'b1, ADDR_KEY, 32'h0000_00aa);
        apb(1'b1, ADDR_CONTROL, ctl | 32'h0000_8000);
        repeat (2) @(posedge pclk);
    endtask

    // Waits, with a bound, for the completion flag.
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            conclude();
        end
    endtask

    // Reset, the register table, then the hand-written sequences.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        mcr = 1'b0;
        wdt = 1'b0;
        rows[0] = '{1'b0, ADDR_CONTROL, 32'h0, 32'h0, 1'b0};
        rows[1] = '{1'b0, ADDR_KEY, 32'h0, 32'h0, 1'b0};
        rows[2] = '{1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0};
        rows[3] = '{1'b1, ADDR_ADR_LOW, 32'h6040, 32'h0, 1'b0};
        rows[4] = '{1'b0, ADDR_ADR_LOW, 32'h0, 32'h6040, 1'b0};
        rows[5] = '{1'b1, ADDR_ADR_UP, 32'h0001, 32'h0, 1'b0};
        rows[6] = '{1'b0, ADDR_ADR_UP, 32'h0, 32'h0001, 1'b0};
        rows[7] = '{1'b0, 16'h0ffc, 32'h0, 32'h0, 1'b1};
        rows[8] = '{1'b1, 16'h0ffc, 32'h1234, 32'h0, 1'b1};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            check("pslverr", 32'(err), 32'(rows[i].err));
            if (!rows[i].wr) begin
                check("prdata", rd, rows[i].exp);
            end
        end
        // Enable and start in one write, then no key, then a broken key.
        apb(1'b1, ADDR_KEY, 32'h55);
        apb(1'b1, ADDR_KEY, 32'haa);
        apb(1'b1, ADDR_CONTROL, 32'hc041);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("start one write", 32'(rd[15]), 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'hc041);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("start no key", 32'(rd[15]), 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h4041);
        apb(1'b1, ADDR_KEY, 32'h55);
        apb(1'b1, ADDR_KEY, 32'h12);
        apb(1'b1, ADDR_KEY, 32'haa);
        apb(1'b1, ADDR_CONTROL, 32'hc041);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("start bad key", 32'(rd[15]), 32'h0);
        check("no completion", 32'(done), 32'h0);
        // Flash row erase; software cannot clear start mid-cycle.
        start_op(32'h4041);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("erase started", 32'(rd[15]), 32'h1);
        check("stall", 32'(cpu_stall), 32'h1);
        apb(1'b1, ADDR_CONTROL, 32'h4041);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("start kept", 32'(rd[15]), 32'h1);
        wait_done();
        check("commit", 32'(commit), 32'h1);
        check("erase kind", 32'(erase), 32'h1);
        check("row", 32'(row), 32'h0001_6040);
        repeat (2) @(posedge pclk);
        check("stall end", 32'(cpu_stall), 32'h0);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("start cleared", 32'(rd[15]), 32'h0);
        check("done sticky", 32'(done), 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h1);
        @(posedge pclk);
        check("done cleared", 32'(done), 32'h0);
        // Fill the row latches, read one back, then program the row.
        for (int k = 0; k < ROW_WORDS; k++) begin
            core.twrite(24'h016040 + 24'(2 * k), 16'ha500 + 16'(k), 1'b0);
            core.twrite(24'h016040 + 24'(2 * k), 16'(k), 1'b1);
        end
        core.tread(24'h016046, td);
        check("latch", 32'(td), 32'ha503);
        apb(1'b0, ADDR_ADR_LOW, 32'h0);
        check("address capture", rd, 32'h6046);
        start_op(32'h4001);
        wait_done();
        check("program kind", 32'(erase), 32'h0);
        check("program row", 32'(row), 32'h0001_6040);
        apb(1'b1, ADDR_STATUS, 32'h1);
        // EEPROM word erase and program at the last word, then a block erase.
        apb(1'b1, ADDR_ADR_UP, 32'h7f);
        apb(1'b1, ADDR_ADR_LOW, 32'hfffe);
        start_op(32'h4044);
        wait_done();
        check("ee no commit", 32'(commit), 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h1);
        core.tread(EE_LAST, td);
        check("ee erased", 32'(td), 32'(ERASED_WORD));
        core.twrite(EE_LAST, 16'hbeef, 1'b0);
        start_op(32'h4004);
        check("ee no stall", 32'(cpu_stall), 32'h0);
        core.tread(EE_LAST, td);
        check("ee busy read", 32'(td), 32'(BUSY_READ_WORD));
        wait_done();
        apb(1'b1, ADDR_STATUS, 32'h1);
        core.tread(EE_LAST, td);
        check("ee word", 32'(td), 32'hbeef);
        start_op(32'h4045);
        wait_done();
        apb(1'b1, ADDR_STATUS, 32'h1);
        core.tread(EE_LAST, td);
        check("ee block", 32'(td), 32'(ERASED_WORD));
        // Block program takes the upper half of the latches; slot 31 holds the last word.
        start_op(32'h4005);
        wait_done();
        apb(1'b1, ADDR_STATUS, 32'h1);
        core.tread(EE_LAST, td);
        check("ee block write", 32'(td), 32'hbeef);
        // A system reset of either source interrupts a running cycle.
        for (int i = 0; i < 2; i++) begin
            start_op(32'h4044);
            @(posedge pclk);
            mcr <= (i == 0);
            wdt <= (i == 1);
            @(posedge pclk);
            mcr <= 1'b0;
            wdt <= 1'b0;
            apb(1'b0, ADDR_CONTROL, 32'h0);
            check("error flag", rd, 32'h2000);
            apb(1'b0, ADDR_ADR_LOW, 32'h0);
            check("low kept", rd, 32'hfffe);
            check("no done", 32'(done), 32'h0);
            apb(1'b1, ADDR_CONTROL, 32'h0);
        end
        // A presetn reset with no cycle running clears the enable bit and the bus answer.
        apb(1'b1, ADDR_CONTROL, 32'h4000);
        presetn <= 1'b0;
        @(posedge pclk);
        check("reset ready", 32'(pready), 32'h0);
        check("reset stall", 32'(cpu_stall), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("reset enable", rd, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
